// *** rtl/i2cs_pkg.sv ***
package i2cs_pkg;

	// ---------------------------------------------------------------
	// Addressing and set sizes
	// ---------------------------------------------------------------
	// The address byte of a write reads 0x36 on the wire
	localparam logic [6:0] SLAVE_ADDR = 7'h1b;
	localparam int SUB_W = 8;
	localparam logic [7:0] SUB_MULTI_LO = 8'h20;
	localparam logic [7:0] SUB_BQ_LO = 8'h60;
	localparam logic [7:0] SUB_BQ_HI = 8'h6f;
	localparam int LEN_W = 5;
	localparam logic [4:0] LEN_BYTE = 5'h01;
	localparam logic [4:0] LEN_WORD = 5'h04;
	localparam logic [4:0] LEN_BQ = 5'h14;
	localparam int SET_W = 160;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// ---------------------------------------------------------------
	// Bus timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_QTR_STD_NS = 2500;
	localparam int T_QTR_FAST_NS = 625;
	localparam logic [8:0] QTR_STD_CYC = 9'((T_QTR_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [8:0] QTR_FAST_CYC = 9'((T_QTR_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ---------------------------------------------------------------
	// States
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		DS_IDLE = 5'h01,
		DS_ADDR = 5'h02,
		DS_SUB = 5'h04,
		DS_WDATA = 5'h08,
		DS_RDATA = 5'h10
	} i2cs_dev_st_e;

	typedef enum logic [4:0] {
		HS_IDLE = 5'h01,
		HS_HOLD = 5'h02,
		HS_START = 5'h04,
		HS_BIT = 5'h08,
		HS_STOP = 5'h10
	} i2cs_host_st_e;

	// ---------------------------------------------------------------
	// Device state records
	// ---------------------------------------------------------------
	typedef struct packed {
		i2cs_dev_st_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic ack;
		logic rd;
		logic [4:0] idx;
		logic [SET_W-1:0] dbuf;
		logic [7:0] tx;
	} i2cs_link_s;

	typedef struct packed {
		logic [7:0] sub;
		logic [7:0] cm_sub;
		logic [4:0] cm_len;
		logic [SET_W-1:0] cm_data;
		logic cm_tog;
	} i2cs_keep_s;

	localparam i2cs_link_s LINK_RST = '{st: DS_ADDR, cnt: 4'h0, sh: 8'h00, ack: 1'b0, rd: 1'b0,
		idx: 5'h00, dbuf: '0, tx: 8'h00};
	localparam i2cs_keep_s KEEP_RST = '{sub: 8'h00, cm_sub: 8'h00, cm_len: 5'h00, cm_data: '0, cm_tog: 1'b0};

	function automatic logic [4:0] set_len(input logic [7:0] sub);
		if (sub < SUB_MULTI_LO) begin
			return LEN_BYTE;
		end else if (sub >= SUB_BQ_LO && sub <= SUB_BQ_HI) begin
			return LEN_BQ;
		end
		return LEN_WORD;
	endfunction : set_len

endpackage : i2cs_pkg

// *** rtl/i2cs_if.sv ***
`timescale 1ns/1ns
interface i2cs_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups: the line is low only while someone drives low
	assign scl = !(m_scl_oe && !m_scl_o);
	assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

	modport host (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
	modport device (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface : i2cs_if

// *** rtl/i2cs_host.sv ***
`timescale 1ns/1ns
module i2cs_host (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	i2cs_if.host BUS,
	input wire logic FAST_I,
	input wire logic CMD_VALID_I,
	output logic CMD_READY_O,
	input wire logic CMD_START_I,
	input wire logic CMD_STOP_I,
	input wire logic CMD_READ_I,
	input wire logic CMD_NACK_I,
	input wire logic [7:0] CMD_DATA_I,
	output logic RSP_VALID_O,
	output logic [7:0] RSP_DATA_O,
	output logic RSP_ACK_O
);
	import i2cs_pkg::*;

	typedef struct packed {
		i2cs_host_st_e st;
		logic [1:0] q;
		logic [8:0] tick;
		logic [3:0] bitn;
		logic [8:0] tx;
		logic [8:0] rx;
		logic stop;
		logic scl_low;
		logic sda_low;
		logic sy1;
		logic sy2;
		logic rsp_v;
		logic [7:0] rsp_data;
		logic rsp_ack;
	} i2cs_hst_s;

	i2cs_hst_s r_reg;
	i2cs_hst_s r_next;
	logic [8:0] qmax;
	logic qdone;

	// ---------------------------------------------------------------
	// Quarter-period sequencer
	// ---------------------------------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.sy1 = BUS.sda;
		r_next.sy2 = r_reg.sy1;
		r_next.rsp_v = 1'b0;
		qmax = FAST_I ? QTR_FAST_CYC : QTR_STD_CYC;
		qdone = (r_reg.tick == 9'(qmax - 9'h001));
		case (r_reg.st)
			HS_IDLE, HS_HOLD: begin
				if (CMD_VALID_I) begin
					r_next.st = (CMD_START_I || r_reg.st == HS_IDLE) ? HS_START : HS_BIT;
					r_next.tx = CMD_READ_I ? {8'hff, CMD_NACK_I} : {CMD_DATA_I, 1'b1};
					r_next.stop = CMD_STOP_I;
					r_next.q = 2'h0;
					r_next.tick = 9'h000;
					r_next.bitn = 4'h0;
					r_next.scl_low = 1'b1;
				end
			end
			default: begin
				r_next.tick = qdone ? 9'h000 : 9'(r_reg.tick + 9'h001);
				if (qdone) begin
					r_next.q = 2'(r_reg.q + 2'h1);
					case (r_reg.q)
						2'h0: r_next.sda_low = (r_reg.st == HS_BIT) ? !r_reg.tx[8] : (r_reg.st == HS_STOP);
						2'h1: r_next.scl_low = 1'b0;
						2'h2: begin
							if (r_reg.st != HS_BIT) begin
								// SDA moves while SCL is high: start falls, stop rises
								r_next.sda_low = (r_reg.st == HS_START);
							end
						end
						default: begin
							r_next.scl_low = 1'b1;
							if (r_reg.st == HS_START) begin
								r_next.st = HS_BIT;
							end else if (r_reg.st == HS_STOP) begin
								r_next.st = HS_IDLE;
								r_next.scl_low = 1'b0;
							end else begin
								// Sample late in the high phase, well after the far end settled
								r_next.rx = {r_reg.rx[7:0], r_reg.sy2};
								r_next.tx = {r_reg.tx[7:0], 1'b1};
								r_next.bitn = 4'(r_reg.bitn + 4'h1);
								if (r_reg.bitn == ACK_SLOT) begin
									r_next.rsp_v = 1'b1;
									r_next.rsp_data = r_reg.rx[7:0];
									r_next.rsp_ack = !r_reg.sy2;
									r_next.st = r_reg.stop ? HS_STOP : HS_HOLD;
								end
							end
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			r_reg <= '{st: HS_IDLE, q: 2'h0, tick: 9'h000, bitn: 4'h0, tx: 9'h1ff, rx: 9'h000, stop: 1'b0,
				scl_low: 1'b0, sda_low: 1'b0, sy1: 1'b1, sy2: 1'b1, rsp_v: 1'b0, rsp_data: 8'h00, rsp_ack: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign CMD_READY_O = (r_reg.st == HS_IDLE) || (r_reg.st == HS_HOLD);
	assign RSP_VALID_O = r_reg.rsp_v;
	assign RSP_DATA_O = r_reg.rsp_data;
	assign RSP_ACK_O = r_reg.rsp_ack;
	assign BUS.m_scl_o = 1'b0;
	assign BUS.m_scl_oe = r_reg.scl_low;
	assign BUS.m_sda_o = 1'b0;
	assign BUS.m_sda_oe = r_reg.sda_low;

endmodule : i2cs_host

// *** rtl/i2cs_device.sv ***
`timescale 1ns/1ns
module i2cs_device (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	i2cs_if.device BUS,
	output logic WR_STB_O,
	output logic [i2cs_pkg::SUB_W-1:0] WR_SUB_O,
	output logic [i2cs_pkg::LEN_W-1:0] WR_LEN_O,
	output logic [i2cs_pkg::SET_W-1:0] WR_DATA_O,
	output logic BUSY_O
);
	import i2cs_pkg::*;

	typedef struct packed {
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [2:0] sy3;
		logic busy;
		logic wr_stb;
		logic [7:0] wr_sub;
		logic [4:0] wr_len;
		logic [SET_W-1:0] wr_data;
	} i2cs_usr_s;

	i2cs_link_s lr_reg;
	i2cs_link_s lr_next;
	i2cs_keep_s kr_reg;
	i2cs_keep_s kr_next;
	i2cs_usr_s u_reg;
	i2cs_usr_s u_next;
	logic [31:0] mem [0:255];
	logic mem_we;
	logic [31:0] mem_wd;
	logic [7:0] byte_in;
	logic [4:0] rlen;
	logic [4:0] wlen;
	logic [4:0] nidx;
	logic start_tog;
	logic stop_tog;
	logic start_ack;
	logic sda_low_reg;
	logic link_rst_n;
	logic [2:0] evt;

	function automatic logic [7:0] pick(input logic [31:0] w, input logic [7:0] s, input logic [4:0] i);
		if (s < SUB_MULTI_LO) begin
			return w[7:0];
		end
		return 8'(w >> {~i[1:0], 3'h0});
	endfunction : pick

	// ---------------------------------------------------------------
	// Start and stop detection on SDA edges
	// ---------------------------------------------------------------
	always_ff @(negedge BUS.sda or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			start_tog <= 1'b0;
		end else if (BUS.scl) begin
			start_tog <= !start_tog;
		end
	end

	always_ff @(posedge BUS.sda or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			stop_tog <= 1'b0;
		end else if (BUS.scl) begin
			stop_tog <= !stop_tog;
		end
	end

	// Start holds the byte engine in reset until SCL falls; the protocol
	// guarantees SDA has long settled by then, so no synchroniser here.
	assign link_rst_n = RESET_N_I && (start_tog == start_ack);

	// ---------------------------------------------------------------
	// Byte engine on SCL rising edges (needs no other clock)
	// ---------------------------------------------------------------
	always_comb begin
		lr_next = lr_reg;
		kr_next = kr_reg;
		mem_we = 1'b0;
		mem_wd = 32'h0000_0000;
		byte_in = {lr_reg.sh[6:0], BUS.sda};
		rlen = (kr_reg.sub < SUB_MULTI_LO) ? LEN_BYTE : LEN_WORD;
		wlen = set_len(kr_reg.sub);
		nidx = 5'(lr_reg.idx + 5'h01);
		if (lr_reg.cnt == ACK_SLOT) begin
			lr_next.cnt = 4'h0;
			lr_next.ack = 1'b0;
			case (lr_reg.st)
				DS_ADDR: begin
					if (!lr_reg.ack) begin
						lr_next.st = DS_IDLE;
					end else if (lr_reg.rd) begin
						lr_next.st = DS_RDATA;
						lr_next.tx = pick(mem[kr_reg.sub], kr_reg.sub, lr_reg.idx);
					end else begin
						lr_next.st = DS_SUB;
					end
				end
				DS_RDATA: begin
					if (BUS.sda) begin
						lr_next.st = DS_IDLE;
					end else begin
						if (nidx == rlen) begin
							kr_next.sub = 8'(kr_reg.sub + 8'h01);
							lr_next.idx = 5'h00;
						end else begin
							lr_next.idx = nidx;
						end
						lr_next.tx = pick(mem[kr_next.sub], kr_next.sub, lr_next.idx);
					end
				end
				default: begin
				end
			endcase
		end else if (lr_reg.st != DS_IDLE) begin
			lr_next.sh = byte_in;
			lr_next.cnt = 4'(lr_reg.cnt + 4'h1);
			if (lr_reg.cnt == 4'h7) begin
				case (lr_reg.st)
					DS_ADDR: begin
						lr_next.ack = (byte_in[7:1] == SLAVE_ADDR);
						lr_next.rd = byte_in[0];
					end
					DS_SUB: begin
						kr_next.sub = byte_in;
						lr_next.idx = 5'h00;
						lr_next.dbuf = '0;
						lr_next.ack = 1'b1;
						lr_next.st = DS_WDATA;
					end
					DS_WDATA: begin
						lr_next.ack = 1'b1;
						lr_next.dbuf = {lr_reg.dbuf[SET_W-9:0], byte_in};
						if (nidx == wlen) begin
							// Only complete sets leave the engine; partial ones die with it
							kr_next.cm_sub = kr_reg.sub;
							kr_next.cm_len = wlen;
							kr_next.cm_data = lr_next.dbuf;
							kr_next.cm_tog = !kr_reg.cm_tog;
							mem_we = 1'b1;
							mem_wd = (wlen == LEN_BQ) ? lr_next.dbuf[SET_W-1 -: 32] : lr_next.dbuf[31:0];
							kr_next.sub = 8'(kr_reg.sub + 8'h01);
							lr_next.idx = 5'h00;
							lr_next.dbuf = '0;
						end else begin
							lr_next.idx = nidx;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge BUS.scl or negedge link_rst_n) begin
		if (!link_rst_n) begin
			lr_reg <= LINK_RST;
		end else begin
			lr_reg <= lr_next;
		end
	end

	always_ff @(posedge BUS.scl or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			kr_reg <= KEEP_RST;
		end else begin
			kr_reg <= kr_next;
		end
	end

	always_ff @(posedge BUS.scl or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			for (int i = 0; i < 256; i++) begin
				mem[i] <= 32'h0000_0000;
			end
		end else if (mem_we) begin
			mem[kr_reg.sub] <= mem_wd;
		end
	end

	// ---------------------------------------------------------------
	// SDA drive, updated only on SCL falling edges
	// ---------------------------------------------------------------
	always_ff @(negedge BUS.scl or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			sda_low_reg <= 1'b0;
			start_ack <= 1'b0;
		end else begin
			start_ack <= start_tog;
			sda_low_reg <= (lr_reg.cnt == ACK_SLOT && lr_reg.ack) ||
				(lr_reg.st == DS_RDATA && lr_reg.cnt < ACK_SLOT && !lr_reg.tx[~lr_reg.cnt[2:0]]);
		end
	end

	// Open drain only; SCL is never touched, so no stretching is possible
	assign BUS.s_sda_o = 1'b0;
	assign BUS.s_sda_oe = sda_low_reg;

	// ---------------------------------------------------------------
	// User side: toggles cross into CLK_I
	// ---------------------------------------------------------------
	always_comb begin
		u_next = u_reg;
		u_next.sy1 = {kr_reg.cm_tog, stop_tog, start_tog};
		u_next.sy2 = u_reg.sy1;
		u_next.sy3 = u_reg.sy2;
		evt = u_reg.sy2 ^ u_reg.sy3;
		u_next.wr_stb = evt[2];
		if (evt[2]) begin
			// Commit fields are stable: the next set is at least nine SCL periods away
			u_next.wr_sub = kr_reg.cm_sub;
			u_next.wr_len = kr_reg.cm_len;
			u_next.wr_data = kr_reg.cm_data;
		end
		if (evt[0]) begin
			u_next.busy = 1'b1;
		end else if (evt[1]) begin
			u_next.busy = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			u_reg <= '{sy1: 3'h0, sy2: 3'h0, sy3: 3'h0, busy: 1'b0, wr_stb: 1'b0, wr_sub: 8'h00,
				wr_len: 5'h00, wr_data: '0};
		end else begin
			u_reg <= u_next;
		end
	end

	assign WR_STB_O = u_reg.wr_stb;
	assign WR_SUB_O = u_reg.wr_sub;
	assign WR_LEN_O = u_reg.wr_len;
	assign WR_DATA_O = u_reg.wr_data;
	assign BUSY_O = u_reg.busy;

endmodule : i2cs_device

// *** tb/i2cs_chk.sv ***
`timescale 1ns/1ns
module i2cs_chk (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_oe,
	input wire logic s_sda_oe,
	input wire logic BUSY_O,
	input wire logic WR_STB_O,
	input wire logic [7:0] WR_SUB_O,
	input wire logic [4:0] WR_LEN_O
);
	import i2cs_pkg::*;
	// ---------------------------------------------------------------
	// Bus events, sampled on the system clock
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);
	sequence s_start;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence s_stop;
		$rose(sda) && scl && $past(scl);
	endsequence
	property p_scl_host;
		scl == !m_scl_oe;
	endproperty
	property p_oe_low;
		$changed(s_sda_oe) |-> !scl;
	endproperty
	property p_oe_high;
		scl && $past(scl) |-> $stable(s_sda_oe);
	endproperty
	property p_start;
		s_start |-> ##[1:5] BUSY_O;
	endproperty
	property p_stop;
		s_stop |-> ##[1:6] !BUSY_O;
	endproperty
	// Busy lags the bus by a few cycles, so look two samples deep
	property p_idle;
		!BUSY_O && !$past(BUSY_O) |-> !s_sda_oe;
	endproperty
	property p_stb_pulse;
		WR_STB_O |=> !WR_STB_O;
	endproperty
	property p_stb_busy;
		WR_STB_O |-> BUSY_O;
	endproperty
	property p_len;
		WR_STB_O |-> ((WR_SUB_O < SUB_MULTI_LO) == (WR_LEN_O == LEN_BYTE));
	endproperty
	a_scl_host: assert property (p_scl_host) else $error("scl driven by device");
	a_oe_low: assert property (p_oe_low) else $error("device sda moved with scl high");
	a_oe_high: assert property (p_oe_high) else $error("device sda unstable in clock high");
	a_start: assert property (p_start) else $error("start not seen");
	a_stop: assert property (p_stop) else $error("stop not seen");
	a_idle: assert property (p_idle) else $error("device drives idle bus");
	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe longer than one cycle");
	a_stb_busy: assert property (p_stb_busy) else $error("strobe outside transfer");
	a_len: assert property (p_len) else $error("set length wrong for subaddress");
	c_word: cover property (WR_STB_O && WR_LEN_O == LEN_WORD);
	c_start: cover property (s_start);
	c_ack: cover property (s_sda_oe && $rose(scl));
endmodule : i2cs_chk

// *** tb/i2c_control_slave_subaddr_tb_top.sv ***
`timescale 1ns/1ns
module i2c_control_slave_subaddr_tb_top;
	import i2cs_pkg::*;
	logic clk, reset_n, fast, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack;
	logic cmd_ready, rsp_valid, rsp_ack, wr_stb, busy;
	logic [7:0] cmd_data, rsp_data, wr_sub;
	logic [4:0] wr_len;
	logic [159:0] wr_data;
	logic [172:0] wr_q[$];
	int mismatches, cmp_count;

	i2cs_if i2cs_if_i ();
	i2cs_host i2cs_host_i (.CLK_I(clk), .RESET_N_I(reset_n), .BUS(i2cs_if_i), .FAST_I(fast),
		.CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_START_I(cmd_start), .CMD_STOP_I(cmd_stop),
		.CMD_READ_I(cmd_read), .CMD_NACK_I(cmd_nack), .CMD_DATA_I(cmd_data), .RSP_VALID_O(rsp_valid),
		.RSP_DATA_O(rsp_data), .RSP_ACK_O(rsp_ack));
	i2cs_device i2cs_device_i (.CLK_I(clk), .RESET_N_I(reset_n), .BUS(i2cs_if_i), .WR_STB_O(wr_stb),
		.WR_SUB_O(wr_sub), .WR_LEN_O(wr_len), .WR_DATA_O(wr_data), .BUSY_O(busy));
	i2cs_chk i2cs_chk_i (.CLK_I(clk), .RESET_N_I(reset_n), .scl(i2cs_if_i.scl), .sda(i2cs_if_i.sda),
		.m_scl_oe(i2cs_if_i.m_scl_oe), .s_sda_oe(i2cs_if_i.s_sda_oe), .BUSY_O(busy), .WR_STB_O(wr_stb),
		.WR_SUB_O(wr_sub), .WR_LEN_O(wr_len));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Sampled mid-cycle, away from the edge that launches the strobe
	always @(negedge clk) begin
		if (wr_stb === 1'b1) begin
			wr_q.push_back({wr_sub, wr_len, wr_data});
		end
	end

	// ---------------------------------------------------------------
	// Reporting and comparison
	// ---------------------------------------------------------------
	task automatic complete_run;
		$display("compares %0d, mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : chk8
	task automatic chk1(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask : chk1
	task automatic chk_wr(input logic [7:0] s, input logic [4:0] l, input logic [159:0] d);
		logic [172:0] got;
		got = 'x;
		if (wr_q.size() > 0) begin
			got = wr_q.pop_front();
		end
		cmp_count++;
		if (got !== {s, l, d}) begin
			mismatches++;
			$display("unexpected write set: expected %h seen %h", {s, l, d}, got);
		end
	endtask : chk_wr

	// ---------------------------------------------------------------
	// One byte command; the bound covers a slow byte with start
	// ---------------------------------------------------------------
	task automatic snd(input logic st, sp, rd, nk, input logic [7:0] d, input logic ack, input logic [7:0] exp_d);
		int n;
		n = 0;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_start = st;
		cmd_stop = sp;
		cmd_read = rd;
		cmd_nack = nk;
		cmd_data = d;
		@(negedge clk);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(negedge clk);
			n++;
		end
		chk1("response", 1'b1, rsp_valid);
		chk8("byte", exp_d, rsp_data);
		chk1("ack", ack, rsp_ack);
	endtask : snd
	task automatic idle_chk;
		repeat (1100) @(negedge clk);
		chk1("busy", 1'b0, busy);
	endtask : idle_chk

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_single_std;
		snd(1, 0, 0, 0, 8'h36, 1, 8'h36);
		snd(0, 0, 0, 0, 8'h05, 1, 8'h05);
		snd(0, 1, 0, 0, 8'hab, 1, 8'hab);
		chk_wr(8'h05, LEN_BYTE, 160'hab);
		idle_chk();
	endtask : t_single_std
	task automatic t_wrong;
		snd(1, 0, 0, 0, 8'h50, 0, 8'h50);
		snd(0, 1, 0, 0, 8'h05, 0, 8'h05);
		idle_chk();
		chk8("sets", 8'h00, 8'(wr_q.size()));
	endtask : t_wrong
	task automatic t_seq_read;
		snd(1, 0, 0, 0, 8'h36, 1, 8'h36);
		snd(0, 0, 0, 0, 8'h10, 1, 8'h10);
		snd(0, 0, 0, 0, 8'h11, 1, 8'h11);
		snd(0, 1, 0, 0, 8'h22, 1, 8'h22);
		chk_wr(8'h10, LEN_BYTE, 160'h11);
		chk_wr(8'h11, LEN_BYTE, 160'h22);
		snd(1, 0, 0, 0, 8'h36, 1, 8'h36);
		snd(0, 0, 0, 0, 8'h10, 1, 8'h10);
		snd(1, 0, 0, 0, 8'h37, 1, 8'h37);
		snd(0, 0, 1, 0, 8'hff, 1, 8'h11);
		snd(0, 1, 1, 1, 8'hff, 0, 8'h22);
		chk8("sets", 8'h00, 8'(wr_q.size()));
	endtask : t_seq_read
	task automatic t_word_partial;
		snd(1, 0, 0, 0, 8'h36, 1, 8'h36);
		snd(0, 0, 0, 0, 8'h5f, 1, 8'h5f);
		for (int i = 1; i <= 7; i++) begin
			snd(0, 0, 0, 0, 8'(i), 1, 8'(i));
		end
		// Four bytes fill 0x5f; the next four open a 20-byte set at 0x60 and stop short
		snd(0, 1, 0, 0, 8'h08, 1, 8'h08);
		chk_wr(8'h5f, LEN_WORD, 160'h01020304);
		idle_chk();
		chk8("sets", 8'h00, 8'(wr_q.size()));
		snd(1, 0, 0, 0, 8'h36, 1, 8'h36);
		snd(0, 0, 0, 0, 8'h5f, 1, 8'h5f);
		snd(1, 0, 0, 0, 8'h37, 1, 8'h37);
		for (int i = 1; i <= 4; i++) begin
			snd(0, 0, 1, 0, 8'hff, 1, 8'(i));
		end
		snd(0, 1, 1, 1, 8'hff, 0, 8'h00);
	endtask : t_word_partial

	initial begin
		{fast, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = 6'h00;
		cmd_data = 8'h00;
		reset_n = 1'b0;
		mismatches = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_single_std();
		@(negedge clk);
		fast = 1'b1;
		t_wrong();
		t_seq_read();
		t_word_partial();
		complete_run();
	end
	// Budget a little above the expected run of about a hundred thousand cycles
	initial begin
		#1150000;
		mismatches++;
		complete_run();
	end
endmodule : i2c_control_slave_subaddr_tb_top
